// ==== src/rtcc_consts.vh ====
`ifndef RTCC_CONSTS_VH
`define RTCC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RTCC_OFS_CTRL      12'h000
`define RTCC_OFS_CNT_LO    12'h004
`define RTCC_OFS_CNT_HI    12'h008
`define RTCC_OFS_MATCH_LO  12'h00c
`define RTCC_OFS_MATCH_HI  12'h010
`define RTCC_OFS_IRQ_STAT  12'h014
`define RTCC_OFS_IRQ_EN    12'h018
`define RTCC_OFS_IRQ_CLR   12'h01c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define RTCC_BIT_BLK_RST   7
`define RTCC_BIT_CNT_EN    6
`define RTCC_BIT_MATCH_EN  5
`define RTCC_BIT_MODE_HI   4
`define RTCC_BIT_MODE_LO   3
`define RTCC_BIT_OMAT      2
`define RTCC_BIT_CNT_RST_N 1
`define RTCC_BIT_XTAL_EN   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTCC_RST_CTRL      8'h00
`define RTCC_RST_IRQ       3'h0

// ----------------------------------------------------------------
// Interrupt event positions
// ----------------------------------------------------------------
`define RTCC_EV_MATCH      0
`define RTCC_EV_WRAP       1
`define RTCC_EV_LOAD_REF   2
`define RTCC_EV_NUM        3

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define RTCC_PRESCALE_EDGES 64
`define RTCC_RELEASE_CYCLES 2
`define RTCC_CNT_WIDTH      40

`endif

// ==== src/rtcc_prescaler.v ====
`timescale 1ns/10ps
`include "rtcc_consts.vh"

module rtcc_prescaler #(
  parameter integer EDGES = `RTCC_PRESCALE_EDGES,
  parameter integer PW    = 6
) (
  // Clock and reset.
  input  wire clk_i,
  input  wire rst_i,
  // Control.
  input  wire run_i,
  input  wire timebase_clk_i,
  // Tick.
  output wire tick_o
);

  // ----------------------------------------------------------------
  // Edge count
  // ----------------------------------------------------------------
  reg          tb_prev_reg;
  reg [PW-1:0] edge_cnt_reg;
  reg          tick_reg;
  wire         tb_rise;

  assign tb_rise = timebase_clk_i & ~tb_prev_reg;
  assign tick_o  = tick_reg;

  // Stopping clears the count, so every restart waits a full period.
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      tb_prev_reg  <= 1'b1;
      edge_cnt_reg <= {PW{1'b0}};
      tick_reg     <= 1'b0;
    end else begin
      tb_prev_reg <= timebase_clk_i;
      tick_reg    <= 1'b0;
      if (tb_rise) begin
        if (edge_cnt_reg == EDGES[PW-1:0] - {{(PW-1){1'b0}}, 1'b1}) begin
          edge_cnt_reg <= {PW{1'b0}};
          tick_reg     <= 1'b1;
        end else begin
          edge_cnt_reg <= edge_cnt_reg + {{(PW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ==== src/rtcc_irq.v ====
`timescale 1ns/10ps
`include "rtcc_consts.vh"

module rtcc_irq #(
  parameter integer N = `RTCC_EV_NUM
) (
  // Clock and reset.
  input  wire         clk_i,
  input  wire         rst_i,
  // Events and software access.
  input  wire [N-1:0] event_i,
  input  wire         clr_wr_i,
  input  wire         en_wr_i,
  input  wire [N-1:0] wdata_i,
  // State.
  output wire [N-1:0] status_o,
  output wire [N-1:0] enable_o,
  output wire         irq_o
);

  // ----------------------------------------------------------------
  // Sticky status and enable
  // ----------------------------------------------------------------
  reg [N-1:0] status_reg;
  reg [N-1:0] enable_reg;
  reg         irq_reg;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_bit
      // A new event in the cycle of its clear keeps the bit set.
      always @(posedge clk_i) begin
        if (rst_i) begin
          status_reg[i] <= 1'b0;
        end else if (event_i[i]) begin
          status_reg[i] <= 1'b1;
        end else if (clr_wr_i && wdata_i[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= `RTCC_RST_IRQ;
      irq_reg    <= 1'b0;
    end else begin
      if (en_wr_i) begin
        enable_reg <= wdata_i;
      end
      irq_reg <= |(status_reg & enable_reg);
    end
  end

  assign status_o = status_reg;
  assign enable_o = enable_reg;
  assign irq_o    = irq_reg;

endmodule

// ==== src/rtcc_top.v ====
`timescale 1ns/10ps
`include "rtcc_consts.vh"

// Function
// - Block reset holds counter; release two cycles later.
// - Counting needs enable set and reset released.
// - First increment after sixty-four timebase edges.
// - Disabling stops prescaler, counter value kept.
// - Counter loads accepted only while counting disabled.
// - Match enabled: outputs high on counter equal match.
// - Match disabled: both outputs stay low.
// - Sequencer output enables regulator on match.
// - Mode field drives oscillator mode output, resets zero.
// - Clear-on-match zeroes counter at match value.
// - Clear-on-match happens at a rising clock edge.
// - Zero match value suppresses clear-on-match.
// - Counter reset low clears all counter bits.
// - Crystal enable low: fabric enable controls oscillator.
// - Crystal enable high: oscillator on, mode from field.
module rtcc_top #(
  parameter integer CW = `RTCC_CNT_WIDTH,
  parameter integer AW = 12
) (
  // Clock and reset.
  input  wire          clk_i,
  input  wire          rst_i,
  // APB slave.
  input  wire          psel_i,
  input  wire          penable_i,
  input  wire          pwrite_i,
  input  wire [AW-1:0] paddr_i,
  input  wire [31:0]   pwdata_i,
  output wire [31:0]   prdata_o,
  output wire          pready_o,
  output wire          pslverr_o,
  // Timebase and fabric control.
  input  wire          timebase_clk_i,
  input  wire          fabric_enable_i,
  // Match outputs.
  output wire          match_out_o,
  output wire          sequencer_match_out_o,
  // Crystal oscillator controls.
  output wire [1:0]    oscillator_mode_out_o,
  output wire          oscillator_select_out_o,
  output wire          oscillator_enable_o,
  output wire [1:0]    oscillator_active_mode_o,
  // Interrupt.
  output wire          irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam integer HW = CW - 32;

  reg  [7:0]               ctrl_reg;
  reg  [CW-1:0]            cnt_reg;
  reg  [CW-1:0]            cnt_next;
  reg  [CW-1:0]            match_reg;
  reg  [1:0]               rel_sr_reg;
  reg                      eq_d_reg;
  reg                      pready_reg;
  reg                      pslverr_reg;
  reg  [31:0]              prdata_reg;
  reg                      match_out_reg;
  reg                      seq_match_reg;
  reg  [1:0]               osc_mode_reg;
  reg                      osc_sel_reg;
  reg                      osc_en_reg;
  reg  [1:0]               osc_act_reg;
  reg  [31:0]              rd_data;
  reg                      rd_hit;
  reg                      wrap_ev;
  reg                      load_ref_ev;

  // ----------------------------------------------------------------
  // Internal nets
  // ----------------------------------------------------------------
  wire                     acc_done;
  wire                     wr_done;
  wire                     blk_rst;
  wire                     cnt_en;
  wire                     run;
  wire                     tick;
  wire                     match_eq;
  wire                     omat_clr;
  wire                     wr_cnt_lo;
  wire                     wr_cnt_hi;
  wire                     wr_irq_clr;
  wire                     wr_irq_en;
  wire [`RTCC_EV_NUM-1:0]  events;
  wire [`RTCC_EV_NUM-1:0]  irq_status;
  wire [`RTCC_EV_NUM-1:0]  irq_enable;
  wire                     irq_w;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state: the answer is prepared a cycle before pready is
  // shown, so writes and reads both land on the pready edge.
  assign acc_done = psel_i & penable_i & pready_reg;
  assign wr_done  = acc_done & pwrite_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else if (psel_i && penable_i && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= ~rd_hit;
      prdata_reg  <= pwrite_i ? 32'h00000000 : rd_data;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Reads have no side effects on any register.
  always @* begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    case (paddr_i)
      `RTCC_OFS_CTRL: begin
        rd_data[7:0] = ctrl_reg;
      end
      `RTCC_OFS_CNT_LO: begin
        rd_data = cnt_reg[31:0];
      end
      `RTCC_OFS_CNT_HI: begin
        rd_data[HW-1:0] = cnt_reg[CW-1:32];
      end
      `RTCC_OFS_MATCH_LO: begin
        rd_data = match_reg[31:0];
      end
      `RTCC_OFS_MATCH_HI: begin
        rd_data[HW-1:0] = match_reg[CW-1:32];
      end
      `RTCC_OFS_IRQ_STAT: begin
        rd_data[`RTCC_EV_NUM-1:0] = irq_status;
      end
      `RTCC_OFS_IRQ_EN: begin
        rd_data[`RTCC_EV_NUM-1:0] = irq_enable;
      end
      // The clear register holds no state, so it reads as zero.
      `RTCC_OFS_IRQ_CLR: begin
        rd_data = 32'h00000000;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Control and match registers
  // ----------------------------------------------------------------
  // Unmapped addresses match no case here, so such writes are dropped.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= `RTCC_RST_CTRL;
      match_reg <= {CW{1'b0}};
    end else if (wr_done) begin
      if (paddr_i == `RTCC_OFS_CTRL) begin
        ctrl_reg <= pwdata_i[7:0];
      end
      if (paddr_i == `RTCC_OFS_MATCH_LO) begin
        match_reg[31:0] <= pwdata_i;
      end
      if (paddr_i == `RTCC_OFS_MATCH_HI) begin
        match_reg[CW-1:32] <= pwdata_i[HW-1:0];
      end
    end
  end

  assign wr_cnt_lo  = wr_done & (paddr_i == `RTCC_OFS_CNT_LO);
  assign wr_cnt_hi  = wr_done & (paddr_i == `RTCC_OFS_CNT_HI);
  assign wr_irq_clr = wr_done & (paddr_i == `RTCC_OFS_IRQ_CLR);
  assign wr_irq_en  = wr_done & (paddr_i == `RTCC_OFS_IRQ_EN);

  // ----------------------------------------------------------------
  // Block reset release
  // ----------------------------------------------------------------
  // Reset asserts at once but releases only after the field has read
  // zero for two clock cycles.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rel_sr_reg <= 2'b11;
    end else begin
      rel_sr_reg <= {rel_sr_reg[0], ctrl_reg[`RTCC_BIT_BLK_RST]};
    end
  end

  assign blk_rst = ctrl_reg[`RTCC_BIT_BLK_RST] | (|rel_sr_reg);
  assign cnt_en  = ctrl_reg[`RTCC_BIT_CNT_EN];
  assign run     = cnt_en & ~blk_rst;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Dropping run also clears the prescaler count.
  rtcc_prescaler #(
    .EDGES (`RTCC_PRESCALE_EDGES),
    .PW    (6)
  ) u_prescaler (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .run_i          (run),
    .timebase_clk_i (timebase_clk_i),
    .tick_o         (tick)
  );

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign match_eq = (cnt_reg == match_reg);
  assign omat_clr = ctrl_reg[`RTCC_BIT_OMAT] & match_eq & (|match_reg);

  // Block reset outranks every other source, so a held block never loads or counts.
  // A load written while counting is enabled still sets its status bit, so software can see that the write was lost.
  always @* begin
    cnt_next    = cnt_reg;
    wrap_ev     = 1'b0;
    load_ref_ev = 1'b0;
    if (blk_rst) begin
      cnt_next = {CW{1'b0}};
    end else if (!ctrl_reg[`RTCC_BIT_CNT_RST_N]) begin
      cnt_next = {CW{1'b0}};
    end else if (omat_clr) begin
      cnt_next = {CW{1'b0}};
    end else if ((wr_cnt_lo || wr_cnt_hi) && !cnt_en) begin
      if (wr_cnt_lo) begin
        cnt_next[31:0] = pwdata_i;
      end else begin
        cnt_next[CW-1:32] = pwdata_i[HW-1:0];
      end
    end else if (tick && run) begin
      cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      wrap_ev  = &cnt_reg;
    end
    if ((wr_cnt_lo || wr_cnt_hi) && cnt_en) begin
      load_ref_ev = 1'b1;
    end
  end

  // Counter only changes on a clock edge, including clear-on-match.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg  <= {CW{1'b0}};
      eq_d_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      eq_d_reg <= match_eq;
    end
  end

  // ----------------------------------------------------------------
  // Match outputs
  // ----------------------------------------------------------------
  // Outputs are registered, so they trail the counter by one cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      match_out_reg <= 1'b0;
      seq_match_reg <= 1'b0;
    end else if (ctrl_reg[`RTCC_BIT_MATCH_EN]) begin
      match_out_reg <= match_eq;
      seq_match_reg <= match_eq;
    end else begin
      match_out_reg <= 1'b0;
      seq_match_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator outputs
  // ----------------------------------------------------------------
  // The mode output always follows the field; the active mode takes it only with the crystal enabled.
  always @(posedge clk_i) begin
    if (rst_i) begin
      osc_mode_reg <= 2'b00;
      osc_sel_reg  <= 1'b0;
      osc_en_reg   <= 1'b0;
      osc_act_reg  <= 2'b00;
    end else begin
      osc_mode_reg <= ctrl_reg[`RTCC_BIT_MODE_HI:`RTCC_BIT_MODE_LO];
      osc_sel_reg  <= ctrl_reg[`RTCC_BIT_XTAL_EN];
      if (ctrl_reg[`RTCC_BIT_XTAL_EN]) begin
        osc_en_reg  <= 1'b1;
        osc_act_reg <= ctrl_reg[`RTCC_BIT_MODE_HI:`RTCC_BIT_MODE_LO];
      end else begin
        osc_en_reg  <= fabric_enable_i;
        osc_act_reg <= 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // The match event fires on the first cycle of equality only, so a parked counter raises it once.
  assign events[`RTCC_EV_MATCH]    = match_eq & ~eq_d_reg;
  assign events[`RTCC_EV_WRAP]     = wrap_ev;
  assign events[`RTCC_EV_LOAD_REF] = load_ref_ev;

  rtcc_irq #(
    .N (`RTCC_EV_NUM)
  ) u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .event_i  (events),
    .clr_wr_i (wr_irq_clr),
    .en_wr_i  (wr_irq_en),
    .wdata_i  (pwdata_i[`RTCC_EV_NUM-1:0]),
    .status_o (irq_status),
    .enable_o (irq_enable),
    .irq_o    (irq_w)
  );

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign prdata_o                 = prdata_reg;
  assign pready_o                 = pready_reg;
  assign pslverr_o                = pslverr_reg;

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  assign match_out_o              = match_out_reg;
  assign sequencer_match_out_o    = seq_match_reg;
  assign oscillator_mode_out_o    = osc_mode_reg;
  assign oscillator_select_out_o  = osc_sel_reg;
  assign oscillator_enable_o      = osc_en_reg;
  assign oscillator_active_mode_o = osc_act_reg;
  assign irq_o                    = irq_w;

endmodule

// ==== tb/rtcc_assertions.sv ====
`timescale 1ns/10ps
// --------------------------------------------------------------
// Checker on the top-level ports
// --------------------------------------------------------------
module rtcc_checker #(
  parameter integer AW = 12
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Register bus.
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [31:0]   pwdata_i,
  input  wire logic          pready_o,
  input  wire logic          pslverr_o,
  // Oscillator, match and interrupt.
  input  wire logic          fabric_enable_i,
  input  wire logic          match_out_o,
  input  wire logic          sequencer_match_out_o,
  input  wire logic [1:0]    oscillator_mode_out_o,
  input  wire logic          oscillator_select_out_o,
  input  wire logic          oscillator_enable_o,
  input  wire logic [1:0]    oscillator_active_mode_o,
  input  wire logic          irq_o
);
  logic [7:0] sh_reg;
  logic       rq_reg;
  wire        wr_ctl = psel_i & penable_i & pready_o & pwrite_i & ~|paddr_i;
  wire        unmap  = |paddr_i[AW-1:5] | |paddr_i[1:0];

  // A shadow of the control register, so outputs can be tied to what software wrote.
  always @(posedge clk_i) begin
    sh_reg <= rst_i ? 8'h00 : (wr_ctl ? pwdata_i[7:0] : sh_reg);
    rq_reg <= rst_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  // The edge after reset is skipped, since the past values there still belong to reset.
  default disable iff (rst_i || rq_reg);

  chk_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_err_map: assert property (pready_o |-> pslverr_o == unmap)
    else $error("error response wrong for address");
  chk_match_off: assert property (!$past(sh_reg[5]) |-> !match_out_o && !sequencer_match_out_o)
    else $error("match output while disabled");
  chk_seq_match: assert property (sequencer_match_out_o == match_out_o)
    else $error("sequencer output differs from match");
  chk_mode_drive: assert property (oscillator_mode_out_o == $past(sh_reg[4:3]))
    else $error("mode output differs from field");
  chk_sel_drive: assert property (oscillator_select_out_o == $past(sh_reg[0]))
    else $error("select output differs from field");
  chk_osc_enable: assert property (oscillator_enable_o == ($past(sh_reg[0]) | $past(fabric_enable_i)))
    else $error("oscillator enable wrong");
  chk_active_mode: assert property (oscillator_active_mode_o == ($past(sh_reg[0]) ? $past(sh_reg[4:3]) : 2'h0))
    else $error("active mode wrong");

  cov_match: cover property ($rose(match_out_o));
  cov_err: cover property (pready_o && pslverr_o);
  cov_irq: cover property ($rose(irq_o));
endmodule

bind rtcc_top rtcc_checker #(.AW(AW)) u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .pslverr_o, .fabric_enable_i, .match_out_o, .sequencer_match_out_o,
  .oscillator_mode_out_o, .oscillator_select_out_o, .oscillator_enable_o, .oscillator_active_mode_o, .irq_o);

// ==== tb/rtcc_osc_model.sv ====
`timescale 1ns/10ps
// --------------------------------------------------------------
// Crystal oscillator and regulator sequencer model
// --------------------------------------------------------------
module rtcc_osc_model #(
  parameter integer DIV = 1
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Controls.
  input  wire logic osc_en_i,
  input  wire logic fab_req_i,
  input  wire logic seq_match_i,
  // Timebase, fabric enable and regulator.
  output wire logic timebase_o,
  output wire logic fabric_en_o,
  output wire logic reg_on_o
);
  logic tb_q = 1'b0;
  int   cnt = 0;

  // A stopped crystal makes no edges, so counting needs the oscillator enabled.
  always @(posedge clk_i) begin
    if (rst_i || !osc_en_i) begin
      cnt <= 0;
    end else if (cnt == DIV - 1) begin
      cnt <= 0;
      tb_q <= ~tb_q;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign timebase_o  = tb_q;
  assign fabric_en_o = fab_req_i;
  assign reg_on_o    = seq_match_i;
endmodule

// ==== tb/rtc_counter_control_bench.sv ====
`timescale 1ns/10ps
module rtc_counter_control_bench;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0;
  logic        fab_req   = 1'b1;
  wire  [31:0] prdata_o;
  wire  [1:0]  oscillator_mode_out_o;
  wire  [1:0]  oscillator_active_mode_o;
  wire         pready_o, pslverr_o, timebase_clk_i, fabric_enable_i, match_out_o, sequencer_match_out_o;
  wire         oscillator_select_out_o, oscillator_enable_o, irq_o, reg_on;
  logic [31:0] rd;
  logic        er;
  int          n;
  int          errors   = 0;
  int          compares = 0;

  always #10 clk_i = ~clk_i;

  rtcc_top DUT (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .timebase_clk_i, .fabric_enable_i, .match_out_o, .sequencer_match_out_o, .oscillator_mode_out_o,
    .oscillator_select_out_o, .oscillator_enable_o, .oscillator_active_mode_o, .irq_o);
  rtcc_osc_model u_osc (.clk_i, .rst_i, .osc_en_i(oscillator_enable_o), .fab_req_i(fab_req),
    .seq_match_i(sequencer_match_out_o), .timebase_o(timebase_clk_i), .fabric_en_o(fabric_enable_i),
    .reg_on_o(reg_on));

  // --------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------
  // The request stands until the rising edge at which pready is seen high; only the watchdog ends a wait.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd        = prdata_o;
    er        = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    test_done;
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(12'h000, 32'h0);
    rc(12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    rc(12'h01c, 32'h0);
    $display("test reset done");
    wr(12'h000, 32'h19);
    rc(12'h000, 32'h19);
    repeat (2) @(negedge clk_i);
    chk({30'h0, oscillator_active_mode_o}, 32'h3);
    wr(12'h000, 32'h08);
    repeat (2) @(negedge clk_i);
    chk({31'h0, oscillator_enable_o}, 32'h1);
    chk({30'h0, oscillator_active_mode_o}, 32'h0);
    @(posedge clk_i);
    fab_req <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk({31'h0, oscillator_enable_o}, 32'h0);
    @(posedge clk_i);
    fab_req <= 1'b1;
    $display("test oscillator done");
    wr(12'h000, 32'h02);
    wr(12'h004, 32'h5);
    rc(12'h004, 32'h5);
    wr(12'h000, 32'h43);
    repeat (110) @(posedge clk_i);
    rc(12'h004, 32'h5);
    repeat (30) @(posedge clk_i);
    rc(12'h004, 32'h6);
    wr(12'h004, 32'h77);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd & 32'h4, 32'h4);
    rc(12'h004, 32'h6);
    wr(12'h000, 32'h03);
    repeat (200) @(posedge clk_i);
    rc(12'h004, 32'h6);
    $display("test count done");
    wr(12'h000, 32'h01);
    rc(12'h004, 32'h0);
    wr(12'h000, 32'hc3);
    repeat (300) @(posedge clk_i);
    rc(12'h004, 32'h0);
    $display("test resets done");
    wr(12'h000, 32'h03);
    wr(12'h008, 32'hff);
    wr(12'h004, 32'hffffffff);
    wr(12'h018, 32'h2);
    wr(12'h000, 32'h43);
    repeat (140) @(posedge clk_i);
    rc(12'h004, 32'h0);
    rc(12'h008, 32'h0);
    chk({31'h0, irq_o}, 32'h1);
    wr(12'h018, 32'h0);
    repeat (2) @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(12'h018, 32'h2);
    wr(12'h01c, 32'h2);
    repeat (2) @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd & 32'h2, 32'h0);
    $display("test wrap done");
    wr(12'h000, 32'h03);
    wr(12'h004, 32'h0);
    wr(12'h00c, 32'h2);
    wr(12'h000, 32'h67);
    n = 0;
    while (match_out_o !== 1'b1 && n < 600) begin
      @(negedge clk_i);
      n++;
    end
    chk({30'h0, sequencer_match_out_o, reg_on}, 32'h3);
    repeat (1500) @(posedge clk_i);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rd < 32'h2}, 32'h1);
    wr(12'h000, 32'h03);
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h47);
    repeat (1500) @(posedge clk_i);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rd > 32'h5}, 32'h1);
    $display("test match done");
    test_done;
  end
endmodule
